// ### occ_pkg.sv
// occ_pkg: register map, field layout and mode codes of the output
// compare channel; shared by the channel and its bench.
package occ_pkg;

   // register word addresses (byte addresses, one aligned word each)
   localparam logic [3:0]  OCC_ADDR_CTRL   = 4'h0;
   localparam logic [3:0]  OCC_ADDR_PRI    = 4'h4;
   localparam logic [3:0]  OCC_ADDR_SEC    = 4'h8;
   localparam logic [3:0]  OCC_ADDR_STAT   = 4'hc;

   // control register field positions
   localparam int          OCC_MODE_LO     = 0;
   localparam int          OCC_TSEL_BIT    = 3;
   localparam int          OCC_FLT_BIT     = 4;
   localparam int          OCC_IDLE_BIT    = 13;
   localparam logic [15:0] OCC_CTRL_WMASK  = 16'h200f;
   localparam logic [15:0] OCC_CTRL_RST    = 16'h0000;
   localparam logic [15:0] OCC_CMP_RST     = 16'h0000;
   localparam logic [15:0] OCC_ZERO16      = 16'h0000;

   // channel index; only the first two may raise a transfer request
   localparam logic [2:0]  OCC_DMA_CHANNELS = 3'h2;

   // channel index limit of the fault interrupt
   localparam logic [2:0]  OCC_FLT_CHANNELS = 3'h4;

   typedef enum logic [2:0] {
      OCC_OFF       = 3'h0,
      OCC_ONE_LOW   = 3'h1,
      OCC_ONE_HIGH  = 3'h2,
      OCC_TOGGLE    = 3'h3,
      OCC_DLY_ONE   = 3'h4,
      OCC_CONT      = 3'h5,
      OCC_PWM       = 3'h6,
      OCC_PWM_FLT   = 3'h7
   } occ_mode_t;

   // avalon-mm slave request bundle
   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } occ_avs_req_t;

endpackage : occ_pkg

// ### occ_channel.sv
// occ_channel: one output compare channel with avalon-mm register access.
// assumes timer counts and idle/fault inputs are synchronous to clk.
// registers are 16 bits wide, in the low half of each 32-bit access.
//
// Overview of operation
// - compare selected timer, change pin on match
// - mode zero: disabled, pin to gpio, no irq
// - one-shot low: start low, match sets, irq rising
// - one-shot high: start high, match clears, irq falling
// - toggle: keep level, invert on match, both edges
// - delayed one-shot: one pulse, irq on fall
// - continuous pulse: repeating pulses, irq each fall
// - pwm: start per primary value, no irq
// - pwm fault: fault falling edge gives irq on channels one to four
// - fault flag bit 4, hardware cleared only
// - bit 3 picks third timer, else second
// - bit 13 halts channel during cpu idle
// - only channels one and two request dma
// - mode in bits 2-0, unimplemented read zero
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps

module occ_channel
   import occ_pkg::*;
#(
   parameter logic [2:0] CHANNEL_ID = 3'h1
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [15:0] second_timer,
   input  wire logic [15:0] third_timer,
   input  wire logic        cpu_idle,
   input  wire logic        shared_fault_input,
   output logic             compare_output_pin,
   output logic             compare_output_pin_oe,
   output logic             compare_irq,
   output logic             compare_dma_req
);

   logic [15:0] compare_control_reg;
   logic [15:0] primary_compare_reg;
   logic [15:0] secondary_compare_reg;
   logic [15:0] duty_r;
   logic        pin_r;
   logic        pulse_done_r;
   logic        fault_prev_r;
   logic        pwm_fault_flag;
   occ_mode_t   mode_r;
   occ_avs_req_t req;
   logic        load_r;

   // bus request bundle
   assign req = '{address: avs_address, read: avs_read, write: avs_write,
                  writedata: avs_writedata, byteenable: avs_byteenable};

   // low lane mask helper used by every register write
   function automatic logic [15:0] occ_merge(input logic [15:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
      logic [15:0] v;
      v = old_v;
      if (be[0])
      begin
         v[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         v[15:8] = wd[15:8];
      end
      return v;
   endfunction : occ_merge

   // channel index against a limit; used by the fault irq and dma gates
   function automatic logic occ_id_upto(input logic [2:0] limit);
      return (CHANNEL_ID <= limit);
   endfunction : occ_id_upto

   logic        wr_go;
   logic        rd_go;
   logic [15:0] tbase;
   logic        run;
   logic        match_pri;
   logic        match_sec;
   logic        fault_fall;
   occ_mode_t   mode_cfg;

   // one wait cycle per access: a write lands at the edge where
   // waitrequest is seen low; read data are loaded one edge earlier,
   // while waitrequest is still high, so they stand at that same edge
   assign wr_go = req.write & ~avs_waitrequest;
   assign rd_go = req.read & avs_waitrequest;
   assign mode_cfg = occ_mode_t'(compare_control_reg[OCC_MODE_LO +: 3]);
   // timer source select
   assign tbase = compare_control_reg[OCC_TSEL_BIT] ? third_timer
                                                    : second_timer;
   // idle stop freezes the output state machine and the fault flag set; a mode load still goes through
   assign run = ~(compare_control_reg[OCC_IDLE_BIT] & cpu_idle);
   // both compares run every cycle; the mode picks which of them count
   assign match_pri = (tbase == primary_compare_reg);
   assign match_sec = (tbase == secondary_compare_reg);
   assign fault_fall = fault_prev_r & ~shared_fault_input;

   // waitrequest handshake: high, then low for one cycle per request
   // a request still held after its taking edge counts as a new one
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         avs_waitrequest <= 1'b1;
      else if ((req.read | req.write) & avs_waitrequest)
         avs_waitrequest <= 1'b0;
      else
         avs_waitrequest <= 1'b1;
   end

   // register writes; timer should be stopped by software first
   // reserved control bits are masked here, so they always read zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         compare_control_reg   <= OCC_CTRL_RST;
         primary_compare_reg   <= OCC_CMP_RST;
         secondary_compare_reg <= OCC_CMP_RST;
      end
      else if (wr_go)
      begin
         case (req.address)
            OCC_ADDR_CTRL: compare_control_reg <= occ_merge(
               compare_control_reg, req.writedata, req.byteenable)
               & OCC_CTRL_WMASK;
            OCC_ADDR_PRI: primary_compare_reg <= occ_merge(
               primary_compare_reg, req.writedata, req.byteenable);
            OCC_ADDR_SEC: secondary_compare_reg <= occ_merge(
               secondary_compare_reg, req.writedata, req.byteenable);
            default: ;
         endcase
      end
   end

   // read mux; unimplemented and unmapped bits read zero
   // data are cleared at the taking edge, so idle cycles read zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (rd_go)
      begin
         case (req.address)
            OCC_ADDR_CTRL: avs_readdata <= {OCC_ZERO16,
               (compare_control_reg & OCC_CTRL_WMASK)
               | (16'(pwm_fault_flag) << OCC_FLT_BIT)};
            OCC_ADDR_PRI:  avs_readdata <= {OCC_ZERO16, primary_compare_reg};
            OCC_ADDR_SEC:  avs_readdata <= {OCC_ZERO16,
                                            secondary_compare_reg};
            OCC_ADDR_STAT: avs_readdata <= {OCC_ZERO16, tbase};
            default:       avs_readdata <= 32'h0000_0000;
         endcase
      end
      else
         avs_readdata <= 32'h0000_0000;
   end

   // fault edge history
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         fault_prev_r <= 1'b1;
      else
         fault_prev_r <= shared_fault_input;
   end

   // fault flag: set by fault, cleared by hardware on leaving mode 111
   // set and clear never meet: the clear only acts outside mode 111
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pwm_fault_flag <= 1'b0;
      else if (mode_cfg != OCC_PWM_FLT)
         pwm_fault_flag <= 1'b0;
      else if (run & fault_fall)
         pwm_fault_flag <= 1'b1;
   end

   // marks the cycle after a mode load: the pin stage still shows the
   // old level there, and that entry step must not count as an edge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         load_r <= 1'b0;
      else
         load_r <= (mode_r != mode_cfg);
   end

   // output state machine; mode change loads the initial pin level
   // a mode load goes through even while idle stop holds the rest
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_r       <= OCC_OFF;
         pin_r        <= 1'b0;
         pulse_done_r <= 1'b0;
         duty_r       <= OCC_CMP_RST;
      end
      else if (mode_r != mode_cfg)
      begin
         mode_r       <= mode_cfg;
         pulse_done_r <= 1'b0;
         duty_r       <= primary_compare_reg;
         case (mode_cfg)
            OCC_ONE_LOW:  pin_r <= 1'b0;
            OCC_ONE_HIGH: pin_r <= 1'b1;
            OCC_TOGGLE:   pin_r <= pin_r;
            OCC_DLY_ONE,
            OCC_CONT:     pin_r <= 1'b0;
            OCC_PWM,
            OCC_PWM_FLT:  pin_r <= (primary_compare_reg != OCC_ZERO16);
            default:      pin_r <= 1'b0;
         endcase
      end
      else if (run)
      begin
         case (mode_r)
            OCC_ONE_LOW:
            begin
               if (match_pri)
                  pin_r <= 1'b1;
            end
            OCC_ONE_HIGH:
            begin
               if (match_pri)
                  pin_r <= 1'b0;
            end
            OCC_TOGGLE:
            begin
               if (match_pri)
                  pin_r <= ~pin_r;
            end
            OCC_DLY_ONE:
            begin
               // single pulse: primary leads, secondary trails
               if (!pulse_done_r && !pin_r && match_pri)
                  pin_r <= 1'b1;
               else if (pin_r && match_sec)
               begin
                  pin_r        <= 1'b0;
                  pulse_done_r <= 1'b1;
               end
            end
            OCC_CONT:
            begin
               if (!pin_r && match_pri)
                  pin_r <= 1'b1;
               else if (pin_r && match_sec)
                  pin_r <= 1'b0;
            end
            OCC_PWM,
            OCC_PWM_FLT:
            begin
               // period boundary at timer zero reloads duty from secondary
               if (tbase == OCC_ZERO16)
               begin
                  duty_r <= secondary_compare_reg;
                  pin_r  <= (secondary_compare_reg != OCC_ZERO16);
               end
               else if (tbase == duty_r)
                  pin_r <= 1'b0;
               // a fault, or a flag still set, holds the pin low
               if (mode_r == OCC_PWM_FLT && (fault_fall | pwm_fault_flag))
                  pin_r <= 1'b0;
            end
            default: pin_r <= 1'b0;
         endcase
      end
   end

   // pin drive: a register stage after pin_r, released when disabled
   // the stage keeps the pin glitch-free, at one clock of latency
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         compare_output_pin    <= 1'b0;
         compare_output_pin_oe <= 1'b0;
      end
      else
      begin
         compare_output_pin    <= pin_r;
         compare_output_pin_oe <= (mode_r != OCC_OFF);
      end
   end

   // interrupt pulse taken from pin edges in the live mode, from the fault falling edge in mode 111 on channels one to four
   logic edge_ok;
   logic pin_rise;
   logic pin_fall;
   logic irq_nxt;
   // no edge is counted while a mode change or its entry level settles
   assign edge_ok = (mode_r == mode_cfg) & ~load_r;
   assign pin_rise = ~compare_output_pin & pin_r & edge_ok;
   assign pin_fall = compare_output_pin & ~pin_r & edge_ok;

   always_comb
   begin
      case (mode_r)
         OCC_ONE_LOW:  irq_nxt = pin_rise;
         OCC_ONE_HIGH: irq_nxt = pin_fall;
         OCC_TOGGLE:   irq_nxt = pin_rise | pin_fall;
         OCC_DLY_ONE,
         OCC_CONT:     irq_nxt = pin_fall;
         OCC_PWM_FLT:  irq_nxt = run & fault_fall
                                 & occ_id_upto(OCC_FLT_CHANNELS);
         default:      irq_nxt = 1'b0;
      endcase
   end

   // irq pulse and dma request, dma only on the first two channels
   // both come from irq_nxt, so a dma request never lags its irq
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         compare_irq     <= 1'b0;
         compare_dma_req <= 1'b0;
      end
      else
      begin
         compare_irq     <= irq_nxt;
         compare_dma_req <= irq_nxt & occ_id_upto(OCC_DMA_CHANNELS);
      end
   end

endmodule : occ_channel

// ### occ_channel_assertions.sv
// occ_chk: port-level checks of the output compare channel
// assumes a bind onto occ_channel, one clock domain, async low reset
`timescale 1ns/1ps
module occ_chk
   import occ_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   input wire logic        compare_output_pin,
   input wire logic        compare_output_pin_oe,
   input wire logic        compare_irq
);
   logic [2:0] mode_r;
   logic       wr_ctrl;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // shadow of the mode field, taken only when the write is accepted
   assign wr_ctrl = avs_write && !avs_waitrequest
                    && avs_address == OCC_ADDR_CTRL;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         mode_r <= 3'h0;
      else if (wr_ctrl)
         mode_r <= avs_writedata[2:0];
   property p_oe;
      wr_ctrl |-> ##[1:3] (compare_output_pin_oe == (mode_r != 3'h0));
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable vs mode");
   property p_off;
      mode_r == 3'h0 && !compare_output_pin_oe |-> !compare_irq;
   endproperty
   a_off: assert property (p_off) else $error("irq while off");
   property p_m1;
      mode_r == OCC_ONE_LOW && compare_irq |-> $rose(compare_output_pin);
   endproperty
   a_m1: assert property (p_m1) else $error("irq without rise");
   property p_m2;
      mode_r == OCC_ONE_HIGH && compare_irq |-> $fell(compare_output_pin);
   endproperty
   a_m2: assert property (p_m2) else $error("irq without fall");
   property p_m3;
      mode_r == OCC_TOGGLE && compare_irq |-> !$stable(compare_output_pin);
   endproperty
   a_m3: assert property (p_m3) else $error("irq without edge");
   property p_pulse;
      (mode_r == OCC_DLY_ONE || mode_r == OCC_CONT) && compare_irq
         |-> $fell(compare_output_pin);
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse irq");
   property p_m6;
      mode_r == OCC_PWM |-> !compare_irq;
   endproperty
   a_m6: assert property (p_m6) else $error("irq in plain pwm");
   property p_ans;
      (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
   endproperty
   a_ans: assert property (p_ans) else $error("bus answer late");
   property p_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_one: assert property (p_one) else $error("wait low too long");
   // main scenarios reached
   c_m1: cover property (mode_r == OCC_ONE_LOW && compare_irq);
   c_m3: cover property (mode_r == OCC_TOGGLE && compare_irq);
   c_m7: cover property (mode_r == OCC_PWM_FLT && compare_irq);
endmodule : occ_chk

// ### occ_load.sv
// occ_load: external load on the compare pin, with a weak pull-down
// assumes pin and enable come straight from the channel
`timescale 1ns/1ps
module occ_load
(
   input  wire logic pin,
   input  wire logic oe,
   output logic      level
);
   // an undriven pin falls to the pull-down, never keeps the last value
   assign level = oe ? pin : 1'b0;
endmodule : occ_load

// ### occ_channel_tb.sv
// occ_channel_tb: self-checking bench of the output compare channel
// assumes occ_pkg, occ_channel, occ_load and occ_chk are compiled first
`timescale 1ns/1ps
module occ_channel_tb;
   import occ_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [15:0] tmr [2] = '{16'hffff, 16'hffff};
   logic        cpu_idle = 1'b0;
   logic        shared_fault_input = 1'b1;
   logic        pin, pin_oe, irq, dma, level, sel;
   logic [31:0] rd;
   logic [15:0] p;
   // per mode: level after entry, after primary hit, after secondary hit
   logic [2:0]  ex [1:7] = '{3'b011, 3'b100, 3'b011, 3'b010, 3'b010,
                             3'b100, 3'b100};
   int          ei [1:7] = '{1, 1, 1, 1, 1, 0, 0};
   int          error_cnt = 0;
   int          tests_run = 0;
   int          irq_n = 0;
   int          dma_n = 0;
   int          base;
   int          cyc = 0;
   int          seed = 32'h14ec;
   occ_channel occ_channel_inst (.clk(clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .second_timer(tmr[0]),
      .third_timer(tmr[1]), .cpu_idle(cpu_idle),
      .shared_fault_input(shared_fault_input),
      .compare_output_pin(pin), .compare_output_pin_oe(pin_oe),
      .compare_irq(irq), .compare_dma_req(dma));
   occ_load occ_load_inst (.pin(pin), .oe(pin_oe), .level(level));
   // clock, irq tally by nba so readers see a settled count
   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      irq_n <= irq_n + int'(irq);
      dma_n <= dma_n + int'(dma);
   end
   // hang guard well above the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      if (^e !== 1'bx)
      begin
         tests_run++;
         if (g !== e)
         begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
         end
      end
   endtask : chk
   // one request held until waitrequest is seen low at an edge
   task automatic bus(input logic [3:0] a, input logic w,
                      input logic [15:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0, d};
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   // selected timer sits on v for one cycle, then parks away
   task automatic hit(input logic [15:0] v);
      tmr[sel] <= v;
      @(posedge clk);
      tmr[sel] <= 16'hffff;
      repeat (4) @(posedge clk);
   endtask : hit
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      chk("oe", 32'h0, {31'h0, pin_oe});
      bus(OCC_ADDR_CTRL, 1'b0, 16'h0);
      chk("ctrl", {16'h0, OCC_CTRL_RST}, rd);
      bus(4'h2, 1'b0, 16'h0);
      chk("unmapped", 32'h0, rd);
      cpu_idle <= 1'b1; // idle bit clear: channel keeps running
      for (int m = 1; m < 8; m++)
      begin
         sel = m[0];
         tmr[0] <= 16'hffff; // timers parked while reconfiguring
         tmr[1] <= 16'hffff;
         p = 16'h0100 + 16'($random(seed) & 32'h3fff);
         bus(OCC_ADDR_PRI, 1'b1, p);
         bus(OCC_ADDR_SEC, 1'b1, p + 16'h0080);
         base = irq_n; // entry levels must raise no irq
         bus(OCC_ADDR_CTRL, 1'b1, {12'h0, sel, 3'(m)});
         bus(OCC_ADDR_CTRL, 1'b0, 16'h0);
         chk("ctrl", {28'h0, sel, 3'(m)}, rd);
         tmr[!sel] <= p; // unselected timer sits on the match value
         repeat (4) @(posedge clk);
         chk("init", {31'h0, ex[m][2]}, {31'h0, level});
         hit(p);
         chk("lead", {31'h0, ex[m][1]}, {31'h0, level});
         hit(p + 16'h0080);
         chk("trail", {31'h0, ex[m][0]}, {31'h0, level});
         chk("irqs", ei[m], irq_n - base);
      end
      // fault in protected pwm: flag, interrupt, pin forced low
      shared_fault_input <= 1'b0;
      repeat (4) @(posedge clk);
      chk("irqs", ei[7] + 1, irq_n - base);
      chk("pin", 32'h0, {31'h0, level});
      bus(OCC_ADDR_CTRL, 1'b0, 16'h0);
      chk("ctrl", 32'h001f, rd);
      bus(OCC_ADDR_CTRL, 1'b1, 16'h0);
      shared_fault_input <= 1'b1;
      bus(OCC_ADDR_CTRL, 1'b0, 16'h0);
      chk("ctrl", 32'h0, rd);
      chk("pin", 32'h0, {31'h0, level});
      bus(OCC_ADDR_CTRL, 1'b1, 16'hffff);
      bus(OCC_ADDR_CTRL, 1'b0, 16'h0);
      chk("ctrl", {16'h0, OCC_CTRL_WMASK}, rd);
      // idle stop: frozen while idle, runs once idle ends
      bus(OCC_ADDR_CTRL, 1'b1, 16'h2001);
      repeat (4) @(posedge clk); // mode load done before the match
      sel = 1'b0;
      base = irq_n;
      hit(p);
      chk("idle", 32'h0, {31'h0, level});
      cpu_idle <= 1'b0;
      hit(p);
      chk("run", 32'h1, {31'h0, level});
      chk("irqs", 1, irq_n - base);
      chk("dma", irq_n, dma_n);
      print_verdict();
   end
endmodule : occ_channel_tb
bind occ_channel occ_chk occ_chk_inst (.clk(clk), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .compare_output_pin(compare_output_pin),
   .compare_output_pin_oe(compare_output_pin_oe),
   .compare_irq(compare_irq));
